// ---- common/flash_ctl_cfg.svh ----
// register offsets, control bit positions, reset values and timing counts of the flash controller
// assumes a plain byte-wide register port; included by the controller, the checker and the bench
// What this block does
// - data low holds word bits 7:0, loaded by reads, sourced by writes
// - data high holds word bits 13:8; bits 7:6 read as zero
// - address low holds address bits 7:0, reset to zero
// - address high holds address bits 14:8; bit 7 reads as one
// - address high top bit and error flag undefined while write busy
// - region select bit 6 picks info/config area or program flash
// - with erase clear, latch-only picks latch load or row program
// - erase bit set erases addressed 32-word row to ones, then clears
// - error flag set on reset during write, broken unlock, protected target
// - hardware never clears the error flag; software may set it
// - program enable bit gates every program and erase
// - write bit starts the chosen self-timed operation, cleared when done
// - write bit set only right after a good unlock sequence
// - writing zero to write bit does not stop a running operation
// - read bit loads data two cycles later, self-clears after one; set only
// - protected erase or row program clears write bit, sets error flag
// - after a row program every write latch resets to 3FFFh
// - config-area read of an invalid address clears both data registers
`ifndef FLASH_CTL_CFG_SVH
`define FLASH_CTL_CFG_SVH

`define OFS_DATA_LOW    3'h0
`define OFS_DATA_HIGH   3'h1
`define OFS_ADDR_LOW    3'h2
`define OFS_ADDR_HIGH   3'h3
`define OFS_CONTROL     3'h4
`define OFS_UNLOCK_KEY  3'h5

`define BIT_REGION      6
`define BIT_LATCH_ONLY  5
`define BIT_ERASE       4
`define BIT_ERROR       3
`define BIT_PROG_EN     2
`define BIT_WRITE       1
`define BIT_READ        0

`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA
`define LATCH_RESET     14'h3FFF
`define ERASED_WORD     14'h3FFF
`define ADDR_HIGH_TOP   8'h80

// self-timed operation lengths
`define ERASE_TIME_US   2
`define PROG_TIME_US    2
`define CLK_MHZ         50

`endif

// ---- common/flash_ctl_pkg.sv ----
// types shared by the flash controller files
// assumes the cfg header is included alongside by each user except the word memory, which needs none of it
package flash_ctl_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_PROG  = 4'b0100,
        ST_LATCH = 4'b1000
    } op_state_t;

    typedef enum logic [2:0] {
        KEY_NONE  = 3'b001,
        KEY_HALF  = 3'b010,
        KEY_ARMED = 3'b100
    } key_state_t;
endpackage

// ---- logic/flash_word_mem.sv ----
// single-port word memory used for the program flash array and the row write latches
// assumes one access per cycle; read data registered
`timescale 1ns/1ns
module flash_word_mem
    import flash_ctl_pkg::*;
#(
    parameter int AW = 15,
    parameter int DW = 14
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    initial begin
        if (AW < 1 || AW > 20 || DW < 1) $error("flash_word_mem: bad size");
    end

    typedef struct packed {
        logic [DW-1:0] rd;
    } mem_st_t;

    logic [DW-1:0] cells [0:(1<<AW)-1];
    mem_st_t st_r;
    mem_st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.rd = cells[addr];
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
        if (we) begin
            cells[addr] <= wdata;
        end
    end

    assign rdata = st_r.rd;
endmodule

// ---- logic/flash_self_program_control.sv ----
// software-visible flash self-program controller: data, address, control and unlock key registers
// assumes single-cycle byte register strobes; write protection and prior reset-abort come as inputs
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "flash_ctl_cfg.svh"
module flash_self_program_control
    import flash_ctl_pkg::*;
#(
    parameter int ROW_WORDS  = 32,
    parameter int ERASE_CYC  = `ERASE_TIME_US * `CLK_MHZ,
    parameter int PROG_CYC   = `PROG_TIME_US * `CLK_MHZ,
    parameter int CFG_BASE   = 'h100,
    parameter int CFG_TOP    = 'h2FF
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    input  wire logic       writeProtect,
    input  wire logic       resetAbortedWrite,
    output logic            busy
);
    localparam int RW = $clog2(ROW_WORDS);
    // a row program walks one extra cycle because latch read data arrive a cycle late
    localparam logic [RW:0] PROG_END = (RW+1)'(ROW_WORDS + 1);

    initial begin
        if (ROW_WORDS < 2 || (1 << RW) != ROW_WORDS) $error("row size must be a power of two");
        if (ERASE_CYC < 1 || PROG_CYC < 1) $error("operation time too short");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [13:0] wordData;
        logic [14:0] wordAddr;
        logic        regionSelect;
        logic        latchOnly;
        logic        eraseSel;
        logic        writeErrorFlag;
        logic        programEnable;
        logic        writeBit;
        logic        readPend;
        logic        readFromCfg;
        logic        cfgInvalid;
        key_state_t  key;
        op_state_t   op;
        logic [15:0] timer;
        logic [RW:0] idx;
        logic [7:0]  rdata;
        logic        abortSeen;
    } ctl_st_t;

    ctl_st_t st_r;
    ctl_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // memories: program array, info area, row write latches

    logic        arrWe;
    logic [14:0] arrAddr;
    logic [13:0] arrWdata;
    logic [13:0] arrRdata;
    logic        cfgWe;
    logic [9:0]  cfgAddr;
    logic [13:0] cfgRdata;
    logic        latWe;
    logic [RW-1:0] latAddr;
    logic [13:0] latWdata;
    logic [13:0] latRdata;

    flash_word_mem #(.AW(15), .DW(14)) u_array (
        .clk   (clk),
        .we    (arrWe),
        .addr  (arrAddr),
        .wdata (arrWdata),
        .rdata (arrRdata)
    );

    flash_word_mem #(.AW(10), .DW(14)) u_cfg (
        .clk   (clk),
        .we    (cfgWe),
        .addr  (cfgAddr),
        .wdata (arrWdata),
        .rdata (cfgRdata)
    );

    flash_word_mem #(.AW(RW), .DW(14)) u_latch (
        .clk   (clk),
        .we    (latWe),
        .addr  (latAddr),
        .wdata (latWdata),
        .rdata (latRdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // user id words are the only writable part of the config region
    function automatic logic cfgWritable(input logic [14:0] a);
        return a[14:2] == 13'h0;
    endfunction

    function automatic logic cfgReadable(input logic [14:0] a);
        logic [14:0] lo;
        lo = a;
        return (lo <= 15'h000B && lo != 15'h0004) ||
               (lo >= 15'(CFG_BASE) && lo <= 15'(CFG_TOP));
    endfunction

    function automatic logic [14:0] rowBase(input logic [14:0] a);
        return {a[14:RW], {RW{1'b0}}};
    endfunction

    logic        wrCtl;
    logic        wrKey;
    logic        protectedHit;
    logic        startOk;
    logic        progDone;
    logic [RW:0] idxPrev;
    logic        readLand_r;
    logic        readLand_nxt;

    assign progDone = st_r.idx == PROG_END;
    assign idxPrev  = st_r.idx - 1'b1;

    assign wrCtl = regWr && regAddr == `OFS_CONTROL;
    assign wrKey = regWr && regAddr == `OFS_UNLOCK_KEY;
    assign protectedHit = writeProtect || (st_r.regionSelect && !cfgWritable(st_r.wordAddr));
    // the enable bit travels in the same write as the write bit, as a read-modify-write would carry it
    assign startOk = wrCtl && regWdata[`BIT_WRITE] && st_r.key == KEY_ARMED
                     && regWdata[`BIT_PROG_EN] && st_r.op == ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt   = st_r;
        arrWe    = 1'b0;
        cfgWe    = 1'b0;
        latWe    = 1'b0;
        arrAddr  = st_r.wordAddr;
        cfgAddr  = st_r.wordAddr[9:0];
        arrWdata = `ERASED_WORD;
        latAddr  = st_r.wordAddr[RW-1:0];
        latWdata = st_r.wordData;

        // register writes
        if (regWr) begin
            unique case (regAddr)
                `OFS_DATA_LOW:  st_nxt.wordData[7:0]   = regWdata;
                `OFS_DATA_HIGH: st_nxt.wordData[13:8]  = regWdata[5:0];
                `OFS_ADDR_LOW:  st_nxt.wordAddr[7:0]   = regWdata;
                `OFS_ADDR_HIGH: st_nxt.wordAddr[14:8]  = regWdata[6:0];
                `OFS_CONTROL: begin
                    st_nxt.regionSelect   = regWdata[`BIT_REGION];
                    st_nxt.latchOnly      = regWdata[`BIT_LATCH_ONLY];
                    st_nxt.programEnable  = regWdata[`BIT_PROG_EN];
                    // software writes the flag freely; hardware only sets it
                    st_nxt.writeErrorFlag = regWdata[`BIT_ERROR];
                    if (st_r.op == ST_IDLE) begin
                        st_nxt.eraseSel = regWdata[`BIT_ERASE];
                    end
                    if (regWdata[`BIT_READ] && st_r.op == ST_IDLE) begin
                        st_nxt.readPend = 1'b1;
                    end
                end
                `OFS_UNLOCK_KEY: ;
                default: ;
            endcase
        end

        // unlock detector: a stray key write or any other write breaks the sequence
        unique case (st_r.key)
            KEY_NONE: if (wrKey && regWdata == `KEY_FIRST) st_nxt.key = KEY_HALF;
            KEY_HALF: begin
                if (wrKey && regWdata == `KEY_SECOND) begin
                    st_nxt.key = KEY_ARMED;
                end else if (regWr) begin
                    st_nxt.key = KEY_NONE;
                    st_nxt.writeErrorFlag = 1'b1;
                end
            end
            KEY_ARMED: begin
                // only the very next write may use the unlock
                if (regWr) begin
                    st_nxt.key = KEY_NONE;
                    if (!wrCtl) st_nxt.writeErrorFlag = 1'b1;
                end
            end
        endcase

        // a reset that cut a write short is reported once after release; placed after
        // the software write so that the hardware set wins
        if (resetAbortedWrite && !st_r.abortSeen) begin
            st_nxt.abortSeen      = 1'b1;
            st_nxt.writeErrorFlag = 1'b1;
        end

        // start of an operation; zero writes to the write bit are never looked at
        if (startOk) begin
            st_nxt.eraseSel  = regWdata[`BIT_ERASE];
            st_nxt.latchOnly = regWdata[`BIT_LATCH_ONLY];
            st_nxt.readPend  = 1'b0;
            if (regWdata[`BIT_ERASE]) begin
                if (protectedHit) begin
                    st_nxt.writeErrorFlag = 1'b1;
                end else begin
                    st_nxt.writeBit = 1'b1;
                    st_nxt.op       = ST_ERASE;
                    st_nxt.idx      = '0;
                    st_nxt.timer    = 16'(ERASE_CYC);
                end
            end else if (regWdata[`BIT_LATCH_ONLY]) begin
                st_nxt.writeBit = 1'b1;
                st_nxt.op       = ST_LATCH;
            end else if (protectedHit) begin
                st_nxt.writeErrorFlag = 1'b1;
            end else begin
                st_nxt.writeBit = 1'b1;
                st_nxt.op       = ST_PROG;
                st_nxt.idx      = '0;
                st_nxt.timer    = 16'(PROG_CYC);
            end
        end

        // operations in progress
        unique case (st_r.op)
            ST_IDLE: ;
            ST_LATCH: begin
                latWe           = 1'b1;
                st_nxt.op       = ST_IDLE;
                st_nxt.writeBit = 1'b0;
            end
            ST_ERASE: begin
                if (!st_r.idx[RW]) begin
                    // touch one word of the row per cycle
                    arrAddr    = rowBase(st_r.wordAddr) | 15'(st_r.idx[RW-1:0]);
                    cfgAddr    = arrAddr[9:0];
                    arrWdata   = `ERASED_WORD;
                    arrWe      = !st_r.regionSelect;
                    cfgWe      = st_r.regionSelect;
                    st_nxt.idx = st_r.idx + 1'b1;
                end
                if (st_r.timer > 16'h0001) begin
                    st_nxt.timer = st_r.timer - 16'h0001;
                end else if (st_r.idx[RW]) begin
                    st_nxt.op       = ST_IDLE;
                    st_nxt.writeBit = 1'b0;
                    st_nxt.eraseSel = 1'b0;
                end
            end
            ST_PROG: begin
                // latch read and latch reset share a cycle; the word reaches the array a cycle later
                if (!st_r.idx[RW]) begin
                    latAddr  = st_r.idx[RW-1:0];
                    latWe    = 1'b1;
                    latWdata = `LATCH_RESET;
                end
                if (st_r.idx != '0 && !progDone) begin
                    arrAddr  = rowBase(st_r.wordAddr) | 15'(idxPrev[RW-1:0]);
                    cfgAddr  = arrAddr[9:0];
                    arrWdata = latRdata;
                    arrWe    = !st_r.regionSelect;
                    cfgWe    = st_r.regionSelect;
                end
                if (!progDone) begin
                    st_nxt.idx = st_r.idx + 1'b1;
                end
                if (st_r.timer > 16'h0001) begin
                    st_nxt.timer = st_r.timer - 16'h0001;
                end else if (progDone) begin
                    st_nxt.op       = ST_IDLE;
                    st_nxt.writeBit = 1'b0;
                    st_nxt.eraseSel = 1'b0;
                end
            end
            default: begin
                st_nxt.op       = ST_IDLE;
                st_nxt.writeBit = 1'b0;
            end
        endcase

        // read: address applied this cycle, data captured next
        if (st_r.readPend) begin
            st_nxt.readPend    = 1'b0;
            st_nxt.readFromCfg = st_r.regionSelect;
            st_nxt.cfgInvalid  = st_r.regionSelect && !cfgReadable(st_r.wordAddr);
        end

        // memory word lands two cycles after the read bit unless software writes the data registers then
        if (readLand_r && !(regWr && (regAddr == `OFS_DATA_LOW || regAddr == `OFS_DATA_HIGH))) begin
            st_nxt.wordData = st_r.cfgInvalid ? 14'h0000
                                              : (st_r.readFromCfg ? cfgRdata : arrRdata);
        end

        // read data back to software
        st_nxt.rdata = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                `OFS_DATA_LOW:  st_nxt.rdata = st_r.wordData[7:0];
                `OFS_DATA_HIGH: st_nxt.rdata = {2'b00, st_r.wordData[13:8]};
                `OFS_ADDR_LOW:  st_nxt.rdata = st_r.wordAddr[7:0];
                // top bit is held at one; software must not trust it while busy
                `OFS_ADDR_HIGH: st_nxt.rdata = `ADDR_HIGH_TOP | {1'b0, st_r.wordAddr[14:8]};
                `OFS_CONTROL:   st_nxt.rdata = {1'b0, st_r.regionSelect, st_r.latchOnly, st_r.eraseSel,
                                                st_r.writeErrorFlag, st_r.programEnable, st_r.writeBit,
                                                st_r.readPend};
                default:        st_nxt.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    assign readLand_nxt = st_r.readPend;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r           <= '0;
            st_r.key       <= KEY_NONE;
            st_r.op        <= ST_IDLE;
            readLand_r     <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            readLand_r <= readLand_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign busy     = st_r.writeBit;
endmodule

// ---- verif/flash_side_model.sv ----
// far side of the controller: protection map and reset-abort record
// assumes the bench steers both requests between register transfers
`timescale 1ns/1ns
module flash_side_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic protReq,
    input  wire logic abortReq,
    output logic      writeProtect,
    output logic      resetAbortedWrite
);
    typedef struct packed {logic prot; logic abort;} side_state_t;
    side_state_t st_r, st_nxt;
    always_comb begin
        st_nxt.prot = protReq;
        // the record survives the reset and drops one cycle after release
        // the record starts unknown at power-up; treat that as no abort
        st_nxt.abort = sys_rst ? ((st_r.abort === 1'b1) | abortReq) : 1'b0;
    end
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end
    assign writeProtect = st_r.prot;
    assign resetAbortedWrite = st_r.abort;
endmodule

// ---- verif/flash_ctl_assertions.sv ----
// port checker for the flash controller, bound to its top module
// assumes one register strobe per cycle and a synchronous reset
`timescale 1ns/1ns
`include "flash_ctl_cfg.svh"
module flash_ctl_checker
    import flash_ctl_pkg::*;
#(
    parameter int ERASE_CYC = 100,
    parameter int PROG_CYC  = 100
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       writeProtect,
    input wire logic       resetAbortedWrite,
    input wire logic       busy
);
    localparam int LONG_E = ERASE_CYC > 32 ? ERASE_CYC : 32;
    localparam int LONG_P = PROG_CYC > 32 ? PROG_CYC : 32;
    typedef struct packed {
        logic half; logic armed; logic lowWr; logic rdCtl; logic errSeen; logic [15:0] len;
    } chk_state_t;
    chk_state_t st_r, st_nxt;
    logic goLong;
    assign goLong = regWr && regAddr == `OFS_CONTROL && regWdata[`BIT_WRITE] && regWdata[`BIT_PROG_EN]
        && st_r.armed && !busy && (regWdata[`BIT_ERASE] || !regWdata[`BIT_LATCH_ONLY]);
    always_comb begin
        st_nxt = st_r;
        if (regWr) begin
            st_nxt.half = regAddr == `OFS_UNLOCK_KEY && regWdata == `KEY_FIRST;
            st_nxt.armed = regAddr == `OFS_UNLOCK_KEY && regWdata == `KEY_SECOND && st_r.half;
        end
        if (regWr && regAddr == `OFS_ADDR_LOW)
            st_nxt.lowWr = 1'b1;
        // error reads taken while busy are undefined, so they are ignored
        st_nxt.rdCtl = regRd && regAddr == `OFS_CONTROL && !busy;
        if (st_r.rdCtl && regRdata[`BIT_ERROR])
            st_nxt.errSeen = 1'b1;
        if (regWr && regAddr == `OFS_CONTROL)
            st_nxt.errSeen = 1'b0;
        st_nxt.len = busy ? st_r.len + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_idle_read_zero: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_dhigh_top_zero: assert property ($past(regRd && regAddr == `OFS_DATA_HIGH) |-> regRdata[7:6] == 2'b00)
        else $error("data high top bits not zero");
    a_alow_reset: assert property ($past(regRd && regAddr == `OFS_ADDR_LOW && !st_r.lowWr) |-> regRdata == 8'h00)
        else $error("address low not zero after reset");
    a_ahigh_top_one: assert property ($past(regRd && regAddr == `OFS_ADDR_HIGH && !busy) |-> regRdata[7])
        else $error("address high top bit not one");
    a_err_sticky: assert property (st_r.rdCtl && st_r.errSeen |-> regRdata[`BIT_ERROR])
        else $error("error flag cleared without software");
    a_go_unlocked: assert property ($rose(busy) |->
        $past(regWr && regAddr == `OFS_CONTROL && regWdata[`BIT_WRITE] && st_r.armed))
        else $error("operation started without unlock");
    a_go_enabled: assert property ($rose(busy) |-> $past(regWdata[`BIT_PROG_EN]))
        else $error("operation started with program enable clear");
    a_busy_length: assert property ($fell(busy) |->
        st_r.len == 16'd1 || st_r.len == 16'(LONG_E) || st_r.len == 16'(LONG_P))
        else $error("busy length wrong");
    a_protect_stop: assert property ($past(goLong && writeProtect) |-> !busy)
        else $error("protected target started an operation");
    c_latch_op: cover property ($fell(busy) && st_r.len == 16'd1);
    c_long_op: cover property ($fell(busy) && st_r.len > 16'd1);
    c_protected: cover property ($past(goLong && writeProtect));
    c_err_read: cover property (st_r.rdCtl && st_r.errSeen);
endmodule
bind flash_self_program_control flash_ctl_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) chk (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .writeProtect(writeProtect), .resetAbortedWrite(resetAbortedWrite), .busy(busy));

// ---- verif/tb_flash_self_program_control.sv ----
// self-checking bench for the flash self-program controller
// assumes the side model supplies protection and the reset-abort record
`timescale 1ns/1ns
`include "flash_ctl_cfg.svh"
module tb_flash_self_program_control
    import flash_ctl_pkg::*;
;
    // short op time keeps the run small; still above the 32-cycle row walk
    localparam int OP_CYC = 40;
    logic       clk, sys_rst, regWr, regRd, writeProtect, resetAbortedWrite, busy, protReq, abortReq;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata;
    int         numErrors = 0;
    int         testsRun = 0;
    flash_self_program_control #(.ERASE_CYC(OP_CYC), .PROG_CYC(OP_CYC)) uut (.clk(clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .writeProtect(writeProtect), .resetAbortedWrite(resetAbortedWrite), .busy(busy));
    flash_side_model side (.clk(clk), .sys_rst(sys_rst), .protReq(protReq), .abortReq(abortReq),
        .writeProtect(writeProtect), .resetAbortedWrite(resetAbortedWrite));
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (numErrors == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        cmp8(what, exp, regRdata);
    endtask
    task automatic go(input logic [7:0] ctl);
        wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
        wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
        wr(`OFS_CONTROL, ctl);
    endtask
    task automatic setAddr(input logic [14:0] w);
        wr(`OFS_ADDR_HIGH, {1'b0, w[14:8]});
        wr(`OFS_ADDR_LOW, w[7:0]);
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 200) begin
            cmp8("busy idle", 8'h00, {7'h00, busy});
            conclude();
        end
    endtask
    task automatic readWord(input logic [14:0] w, input logic region, input logic [13:0] exp);
        setAddr(w);
        wr(`OFS_CONTROL, region ? 8'h41 : 8'h01);
        repeat (2) @(posedge clk);
        chk("data low", `OFS_DATA_LOW, exp[7:0]);
        chk("data high", `OFS_DATA_HIGH, {2'b00, exp[13:8]});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic tResetValues();
        chk("addr low", `OFS_ADDR_LOW, 8'h00);
        chk("addr high", `OFS_ADDR_HIGH, `ADDR_HIGH_TOP);
        chk("control", `OFS_CONTROL, 8'h00);
        chk("data high", `OFS_DATA_HIGH, 8'h00);
    endtask
    task automatic tRegisters();
        wr(`OFS_DATA_LOW, 8'hA5);
        wr(`OFS_DATA_HIGH, 8'hFF);
        chk("data low", `OFS_DATA_LOW, 8'hA5);
        chk("data high", `OFS_DATA_HIGH, 8'h3F);
        wr(`OFS_ADDR_HIGH, 8'h7F);
        chk("addr high", `OFS_ADDR_HIGH, 8'hFF);
        wr(`OFS_ADDR_HIGH, 8'h00);
        chk("addr high", `OFS_ADDR_HIGH, 8'h80);
        wr(`OFS_ADDR_LOW, 8'h5A);
        chk("addr low", `OFS_ADDR_LOW, 8'h5A);
    endtask
    task automatic tUnlock();
        wr(`OFS_CONTROL, 8'h06);
        cmp8("busy", 8'h00, {7'h00, busy});
        wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
        wr(`OFS_DATA_LOW, 8'h11);
        chk("control", `OFS_CONTROL, 8'h0C);
        wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
        wr(`OFS_CONTROL, 8'h0E);
        cmp8("busy", 8'h00, {7'h00, busy});
        chk("control", `OFS_CONTROL, 8'h0C);
        wr(`OFS_CONTROL, 8'h04);
        chk("control", `OFS_CONTROL, 8'h04);
        go(8'h02);
        cmp8("busy", 8'h00, {7'h00, busy});
        chk("control", `OFS_CONTROL, 8'h00);
    endtask
    task automatic tProgram();
        setAddr(15'h0040);
        wr(`OFS_DATA_LOW, 8'h34);
        wr(`OFS_DATA_HIGH, 8'h12);
        go(8'h26);
        cmp8("busy", 8'h01, {7'h00, busy});
        @(posedge clk);
        #1;
        cmp8("busy", 8'h00, {7'h00, busy});
        go(8'h06);
        cmp8("busy", 8'h01, {7'h00, busy});
        wr(`OFS_CONTROL, 8'h04);
        cmp8("busy", 8'h01, {7'h00, busy});
        waitIdle();
        readWord(15'h0040, 1'b0, 14'h1234);
        chk("control", `OFS_CONTROL, 8'h00);
        setAddr(15'h0040);
        go(8'h06);
        waitIdle();
        readWord(15'h0040, 1'b0, `LATCH_RESET);
    endtask
    task automatic tErase();
        setAddr(15'h0045);
        wr(`OFS_DATA_LOW, 8'h00);
        wr(`OFS_DATA_HIGH, 8'h00);
        go(8'h26);
        waitIdle();
        go(8'h06);
        waitIdle();
        readWord(15'h0045, 1'b0, 14'h0000);
        // erase aimed at the last word of the row must still hit word 45h
        setAddr(15'h005F);
        go(8'h16);
        waitIdle();
        chk("control", `OFS_CONTROL, 8'h04);
        readWord(15'h0045, 1'b0, `ERASED_WORD);
        readWord(15'h0045, 1'b1, 14'h0000);
    endtask
    task automatic tProtect();
        @(posedge clk);
        protReq <= 1'b1;
        setAddr(15'h0040);
        go(8'h06);
        cmp8("busy", 8'h00, {7'h00, busy});
        chk("control", `OFS_CONTROL, 8'h0C);
        go(8'h26);
        cmp8("busy", 8'h01, {7'h00, busy});
        protReq <= 1'b0;
        waitIdle();
    endtask
    task automatic tResetAbort();
        setAddr(15'h0080);
        go(8'h06);
        @(posedge clk);
        sys_rst <= 1'b1;
        abortReq <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        abortReq <= 1'b0;
        chk("control", `OFS_CONTROL, 8'h08);
        chk("addr low", `OFS_ADDR_LOW, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        regAddr = 3'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        protReq = 1'b0;
        abortReq = 1'b0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        tResetValues();
        tRegisters();
        tUnlock();
        tProgram();
        tErase();
        tProtect();
        tResetAbort();
        conclude();
    end
endmodule
